// [shared/lock_pkg.sv]
package lock_pkg;
   localparam int NUM_DN = 4;
   localparam int PORT_W = 2;
   localparam int STS_W = 8;
   localparam int LOCK_BIT = 0;
   localparam logic [STS_W-1:0] STS_RST = 8'h00;
   localparam logic [PORT_W-1:0] PORT_RST = 2'h0;

   typedef enum logic [3:0] {
      TLP_MWR,
      TLP_MRD,
      TLP_MRDLK,
      TLP_CPL,
      TLP_CPLD,
      TLP_CPLLK,
      TLP_CPLDLK,
      TLP_UNLOCK,
      TLP_MSG,
      TLP_CFG
   } tlp_t;

   typedef enum {
      ST_IDLE,
      ST_DS_LOCK,
      ST_SW_LOCK,
      ST_FAIL_HELD
   } lock_st_t;

   function automatic logic legal_in_lock(input tlp_t t);
      return (t == TLP_MWR) || (t == TLP_MRDLK) || (t == TLP_UNLOCK);
   endfunction
endpackage

// [shared/lock_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface lock_link_if;
   import lock_pkg::*;
   // Root to switch upstream port
   logic                dn_valid;
   logic                dn_ready;
   tlp_t                dn_type;
   logic [PORT_W-1:0]   dn_port;
   // Switch upstream port to root
   logic                up_valid;
   logic                up_ready;
   tlp_t                up_type;
   logic [PORT_W-1:0]   up_port;

   modport sw (input dn_valid, dn_type, dn_port, up_ready, output dn_ready, up_valid, up_type, up_port);
   modport rc (output dn_valid, dn_type, dn_port, up_ready, input dn_ready, up_valid, up_type, up_port);
endinterface
`default_nettype wire

// [hw/switch_bus_lock_control.sv]
`timescale 1ns/1ns
`default_nettype none
module switch_bus_lock_control (
   // Clock and reset
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   // Link to the root
   lock_link_if.sw                            lnk,
   // Egress toward downstream ports
   output logic                               o_ds_tx_valid,
   output lock_pkg::tlp_t                     o_ds_tx_type,
   output logic [lock_pkg::PORT_W-1:0]        o_ds_tx_port,
   input  wire logic                          i_ds_tx_ready,
   input  wire logic [lock_pkg::NUM_DN-1:0]   i_ds_posted_pend,
   // Completions from downstream ports
   input  wire logic                          i_ds_cpl_valid,
   input  wire lock_pkg::tlp_t                i_ds_cpl_type,
   input  wire logic [lock_pkg::PORT_W-1:0]   i_ds_cpl_port,
   input  wire logic                          i_ds_cpl_posted_pend,
   output logic                               o_ds_cpl_ready,
   // Inserted messages
   input  wire logic                          i_msg_valid,
   input  wire lock_pkg::tlp_t                i_msg_type,
   input  wire logic [lock_pkg::PORT_W-1:0]   i_msg_port,
   output logic                               o_msg_ready,
   // Posted requests from upstream still queued
   input  wire logic                          i_up_posted_pend,
   // Blocking and status
   output logic [lock_pkg::NUM_DN-1:0]        o_blk_to_ds,
   output logic                               o_blk_to_up,
   output logic [lock_pkg::PORT_W-1:0]        o_lock_port,
   output logic [lock_pkg::STS_W-1:0]         o_switch_status_reg
);
   import lock_pkg::*;

   lock_st_t            state_r;
   lock_st_t            state_nxt;
   logic [PORT_W-1:0]   lock_port_r;
   logic [PORT_W-1:0]   lock_port_nxt;

   logic                dn_rdy_r;
   logic                hold_v_r;
   tlp_t                hold_type_r;
   logic [PORT_W-1:0]   hold_port_r;

   logic                ds_v_r;
   tlp_t                ds_type_r;
   logic [PORT_W-1:0]   ds_port_r;

   logic                up_v_r;
   tlp_t                up_type_r;
   logic [PORT_W-1:0]   up_port_r;
   logic                cpl_rdy_r;
   logic                msg_rdy_r;

   logic                hold_take;
   logic                ds_free;
   logic                order_ok;
   logic                issue;
   logic                cpl_take;
   logic                msg_take;
   logic                cpl_ok;
   logic                up_busy_nxt;
   logic                cpl_open;
   logic                msg_open;

   assign hold_take = lnk.dn_valid & dn_rdy_r;
   assign ds_free   = !ds_v_r | i_ds_tx_ready;
   assign cpl_take  = i_ds_cpl_valid & cpl_rdy_r;
   assign msg_take  = i_msg_valid & msg_rdy_r;

   // Ordering gate for the request waiting to go downstream
   always_comb begin
      case (hold_type_r)
         TLP_MRDLK: order_ok = !i_ds_posted_pend[hold_port_r];
         TLP_UNLOCK: order_ok = !i_up_posted_pend;
         default: order_ok = 1'b1;
      endcase
   end

   assign issue = hold_v_r & ds_free & order_ok;

   // CplDLk waits for posted traffic ahead of it
   assign cpl_ok = (i_ds_cpl_type != TLP_CPLDLK) | !i_ds_cpl_posted_pend;
   assign up_busy_nxt = (up_v_r & !lnk.up_ready) | cpl_take | msg_take;
   // Whole-switch lock holds upstream traffic from other ports
   assign cpl_open = !o_blk_to_up | (i_ds_cpl_port == lock_port_r);
   assign msg_open = !o_blk_to_up | (i_msg_port == lock_port_r);

   // Lock sequence
   always_comb begin
      state_nxt = state_r;
      lock_port_nxt = lock_port_r;
      if (issue && hold_type_r == TLP_MRDLK && state_r == ST_IDLE) begin
         state_nxt = ST_DS_LOCK;
         lock_port_nxt = hold_port_r;
      end else if (issue && hold_type_r == TLP_UNLOCK) begin
         state_nxt = ST_IDLE;
      end else if (cpl_take && state_r == ST_DS_LOCK && i_ds_cpl_port == lock_port_r) begin
         case (i_ds_cpl_type)
            TLP_CPLDLK: state_nxt = ST_SW_LOCK;
            TLP_CPLLK: state_nxt = ST_FAIL_HELD;
            default: state_nxt = state_r;
         endcase
      end
      // Later MRdLk, MWr and lock completions leave the state alone
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         lock_port_r <= PORT_RST;
      end else begin
         state_r <= state_nxt;
         lock_port_r <= lock_port_nxt;
      end
   end

   // Request from the root, one held at a time
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         dn_rdy_r <= 1'b0;
         hold_v_r <= 1'b0;
         hold_type_r <= TLP_MWR;
         hold_port_r <= PORT_RST;
      end else begin
         if (hold_take) begin
            hold_v_r <= 1'b1;
            hold_type_r <= lnk.dn_type;
            hold_port_r <= lnk.dn_port;
         end else if (issue) begin
            hold_v_r <= 1'b0;
         end
         dn_rdy_r <= !(hold_take | (hold_v_r & !issue));
      end
   end

   // Egress register toward downstream ports
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ds_v_r <= 1'b0;
         ds_type_r <= TLP_MWR;
         ds_port_r <= PORT_RST;
      end else if (issue) begin
         ds_v_r <= 1'b1;
         ds_type_r <= hold_type_r;
         ds_port_r <= hold_port_r;
      end else if (i_ds_tx_ready) begin
         ds_v_r <= 1'b0;
      end
   end

   // Completions take precedence over inserted messages
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cpl_rdy_r <= 1'b0;
         msg_rdy_r <= 1'b0;
      end else begin
         cpl_rdy_r <= !up_busy_nxt & !cpl_take & i_ds_cpl_valid & cpl_ok & cpl_open;
         msg_rdy_r <= !up_busy_nxt & !msg_take & i_msg_valid & msg_open
                      & !(i_ds_cpl_valid & cpl_ok & cpl_open);
      end
   end

   // Upstream output register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         up_v_r <= 1'b0;
         up_type_r <= TLP_CPL;
         up_port_r <= PORT_RST;
      end else if (cpl_take) begin
         up_v_r <= 1'b1;
         up_type_r <= i_ds_cpl_type;
         up_port_r <= i_ds_cpl_port;
      end else if (msg_take) begin
         up_v_r <= 1'b1;
         up_type_r <= i_msg_type;
         up_port_r <= i_msg_port;
      end else if (lnk.up_ready) begin
         up_v_r <= 1'b0;
      end
   end

   // Block masks for non-root sources; held traffic waits, never dropped here
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DN; gi++) begin : g_blk
         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               o_blk_to_ds[gi] <= 1'b0;
            end else begin
               o_blk_to_ds[gi] <= (state_nxt != ST_IDLE) && (lock_port_nxt == PORT_W'(gi));
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_blk_to_up <= 1'b0;
         o_lock_port <= PORT_RST;
         o_switch_status_reg <= STS_RST;
      end else begin
         // Upstream stays open while only the downstream port is locked
         o_blk_to_up <= (state_nxt == ST_SW_LOCK) || (state_nxt == ST_FAIL_HELD);
         o_lock_port <= lock_port_nxt;
         o_switch_status_reg <= STS_RST;
         // Readable at any time, lock or not
         o_switch_status_reg[LOCK_BIT] <= (state_nxt == ST_SW_LOCK);
      end
   end

   assign lnk.dn_ready = dn_rdy_r;
   assign lnk.up_valid = up_v_r;
   assign lnk.up_type = up_type_r;
   assign lnk.up_port = up_port_r;
   assign o_ds_tx_valid = ds_v_r;
   assign o_ds_tx_type = ds_type_r;
   assign o_ds_tx_port = ds_port_r;
   assign o_ds_cpl_ready = cpl_rdy_r;
   assign o_msg_ready = msg_rdy_r;
endmodule
`default_nettype wire

// [hw/lock_root_port.sv]
`timescale 1ns/1ns
`default_nettype none
module lock_root_port (
   // Clock and reset
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   // Link to the switch
   lock_link_if.rc                            lnk,
   // Requests from root logic
   input  wire logic                          i_req_valid,
   input  wire lock_pkg::tlp_t                i_req_type,
   input  wire logic [lock_pkg::PORT_W-1:0]   i_req_port,
   output logic                               o_req_ready,
   output logic                               o_req_refused,
   // Answers from the switch
   output logic                               o_rsp_valid,
   output lock_pkg::tlp_t                     o_rsp_type,
   output logic [lock_pkg::PORT_W-1:0]        o_rsp_port,
   // Lock view
   output logic                               o_lock_open,
   output logic                               o_sw_locked
);
   import lock_pkg::*;

   logic                req_rdy_r;
   logic                dn_v_r;
   tlp_t                dn_type_r;
   logic [PORT_W-1:0]   dn_port_r;
   logic                up_rdy_r;
   logic                open_r;
   logic                locked_r;
   logic [PORT_W-1:0]   lock_port_r;
   logic                take;
   logic                refuse;
   logic                send;
   logic                up_take;

   assign take = i_req_valid & req_rdy_r;
   // Inside a lock only legal kinds to the locked port go out
   assign refuse = take & open_r & (!legal_in_lock(i_req_type) | (i_req_port != lock_port_r));
   assign send = take & !refuse;
   assign up_take = lnk.up_valid & up_rdy_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         dn_v_r <= 1'b0;
         dn_type_r <= TLP_MWR;
         dn_port_r <= PORT_RST;
         req_rdy_r <= 1'b0;
         o_req_refused <= 1'b0;
      end else begin
         if (send) begin
            dn_v_r <= 1'b1;
            dn_type_r <= i_req_type;
            dn_port_r <= i_req_port;
         end else if (lnk.dn_ready) begin
            dn_v_r <= 1'b0;
         end
         req_rdy_r <= !(send | take | (dn_v_r & !lnk.dn_ready));
         o_req_refused <= refuse;
      end
   end

   // Lock tracking; it stays open until Unlock leaves
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         open_r <= 1'b0;
         locked_r <= 1'b0;
         lock_port_r <= PORT_RST;
      end else begin
         if (send && i_req_type == TLP_UNLOCK) begin
            open_r <= 1'b0;
            locked_r <= 1'b0;
         end else begin
            if (send && i_req_type == TLP_MRDLK && !open_r) begin
               open_r <= 1'b1;
               lock_port_r <= i_req_port;
            end
            if (up_take && open_r && lnk.up_type == TLP_CPLDLK) begin
               locked_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         up_rdy_r <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_type <= TLP_CPL;
         o_rsp_port <= PORT_RST;
      end else begin
         up_rdy_r <= 1'b1;
         o_rsp_valid <= up_take;
         if (up_take) begin
            o_rsp_type <= lnk.up_type;
            o_rsp_port <= lnk.up_port;
         end
      end
   end

   assign lnk.dn_valid = dn_v_r;
   assign lnk.dn_type = dn_type_r;
   assign lnk.dn_port = dn_port_r;
   assign lnk.up_ready = up_rdy_r;
   assign o_req_ready = req_rdy_r;
   assign o_lock_open = open_r;
   assign o_sw_locked = locked_r;
endmodule
`default_nettype wire

// [sim/lock_link_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module lock_link_monitor (
   // Clock and reset
   input wire logic                      i_clk_sys,
   input wire logic                      i_rst,
   // Link signals
   input wire logic                      dn_valid,
   input wire logic                      dn_ready,
   input wire lock_pkg::tlp_t            dn_type,
   input wire logic [lock_pkg::PORT_W-1:0] dn_port,
   input wire logic                      up_valid,
   input wire logic                      up_ready,
   input wire lock_pkg::tlp_t            up_type,
   input wire logic [lock_pkg::PORT_W-1:0] up_port
);
   import lock_pkg::*;
   logic              take;
   logic              open_r;
   logic [PORT_W-1:0] port_r;
   logic              sw_r;
   assign take = dn_valid && dn_ready;
   // Lock opened by MRdLk, closed by Unlock
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) open_r <= 1'b0;
      else if (take && dn_type == TLP_MRDLK) open_r <= 1'b1;
      else if (take && dn_type == TLP_UNLOCK) open_r <= 1'b0;
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) port_r <= '0;
      else if (take && dn_type == TLP_MRDLK && !open_r) port_r <= dn_port;
   end
   // Whole-switch lock seen by the root, until Unlock is taken
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) sw_r <= 1'b0;
      else if (take && dn_type == TLP_UNLOCK) sw_r <= 1'b0;
      else if (up_valid && up_ready && open_r && up_type == TLP_CPLDLK) sw_r <= 1'b1;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_dn_wait; dn_valid && !dn_ready; endsequence
   sequence s_dn_take; dn_valid && dn_ready; endsequence
   sequence s_up_wait; up_valid && !up_ready; endsequence
   chk_dn_valid_held:
      assert property (s_dn_wait |=> dn_valid) else $error("dn valid dropped");
   chk_dn_desc_stable:
      assert property (s_dn_wait |=> $stable(dn_type) && $stable(dn_port)) else $error("dn desc moved");
   chk_up_valid_held:
      assert property (s_up_wait |=> up_valid) else $error("up valid dropped");
   chk_up_desc_stable:
      assert property (s_up_wait |=> $stable(up_type) && $stable(up_port)) else $error("up desc moved");
   chk_dn_one_outstanding:
      assert property (s_dn_take |=> !dn_ready) else $error("dn ready after take");
   chk_lock_type_legal:
      assert property (take && open_r |-> legal_in_lock(dn_type)) else $error("illegal type in lock");
   chk_lock_no_cfg:
      assert property (take && open_r |-> dn_type != TLP_CFG) else $error("config in lock");
   chk_lock_same_port:
      assert property (take && open_r |-> dn_port == port_r) else $error("other port in lock");
   chk_up_lock_port_only:
      assert property (up_valid && sw_r |-> up_port == port_r) else $error("other port upstream in lock");
endmodule
`default_nettype wire

// [sim/switch_bus_lock_control_test.sv]
`timescale 1ns/1ns
`default_nettype none
module switch_bus_lock_control_test;
   import lock_pkg::*;
   logic              i_clk_sys, i_rst, i_req_valid, o_req_ready, o_req_refused;
   logic              o_rsp_valid, o_lock_open, o_sw_locked, o_ds_tx_valid, i_ds_tx_ready;
   logic              i_ds_cpl_valid, i_ds_cpl_posted_pend, o_ds_cpl_ready, i_msg_valid;
   logic              o_msg_ready, i_up_posted_pend, o_blk_to_up;
   tlp_t              i_req_type, o_rsp_type, o_ds_tx_type, i_ds_cpl_type, i_msg_type;
   logic [PORT_W-1:0] i_req_port, o_rsp_port, o_ds_tx_port, i_ds_cpl_port, i_msg_port, o_lock_port;
   logic [NUM_DN-1:0] i_ds_posted_pend, o_blk_to_ds;
   logic [STS_W-1:0]  o_switch_status_reg;
   int                n_errors = 0;
   int                n_compared = 0;
   lock_link_if lock_link_if_i ();
   switch_bus_lock_control switch_bus_lock_control_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .lnk(lock_link_if_i), .o_ds_tx_valid(o_ds_tx_valid), .o_ds_tx_type(o_ds_tx_type),
      .o_ds_tx_port(o_ds_tx_port), .i_ds_tx_ready(i_ds_tx_ready), .i_ds_posted_pend(i_ds_posted_pend),
      .i_ds_cpl_valid(i_ds_cpl_valid), .i_ds_cpl_type(i_ds_cpl_type), .i_ds_cpl_port(i_ds_cpl_port),
      .i_ds_cpl_posted_pend(i_ds_cpl_posted_pend), .o_ds_cpl_ready(o_ds_cpl_ready),
      .i_msg_valid(i_msg_valid), .i_msg_type(i_msg_type), .i_msg_port(i_msg_port),
      .o_msg_ready(o_msg_ready), .i_up_posted_pend(i_up_posted_pend), .o_blk_to_ds(o_blk_to_ds),
      .o_blk_to_up(o_blk_to_up), .o_lock_port(o_lock_port), .o_switch_status_reg(o_switch_status_reg));
   lock_root_port lock_root_port_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .lnk(lock_link_if_i),
      .i_req_valid(i_req_valid), .i_req_type(i_req_type), .i_req_port(i_req_port),
      .o_req_ready(o_req_ready), .o_req_refused(o_req_refused), .o_rsp_valid(o_rsp_valid),
      .o_rsp_type(o_rsp_type), .o_rsp_port(o_rsp_port), .o_lock_open(o_lock_open),
      .o_sw_locked(o_sw_locked));
   lock_link_monitor lock_link_monitor_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .dn_valid(lock_link_if_i.dn_valid), .dn_ready(lock_link_if_i.dn_ready),
      .dn_type(lock_link_if_i.dn_type), .dn_port(lock_link_if_i.dn_port),
      .up_valid(lock_link_if_i.up_valid), .up_ready(lock_link_if_i.up_ready),
      .up_type(lock_link_if_i.up_type), .up_port(lock_link_if_i.up_port));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // Bounded wait for a level seen after an edge
   task automatic wait_hi(ref logic s);
      int k;
      for (k = 0; k < 50 && s !== 1'b1; k++) tick(1);
      if (s !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t wait ran out", $time);
      end
   endtask
   task automatic send(input tlp_t t, input logic [PORT_W-1:0] p, output logic refd);
      i_req_valid = 1'b1;
      i_req_type = t;
      i_req_port = p;
      wait_hi(o_req_ready);
      tick(1);
      refd = o_req_refused;
      i_req_valid = 1'b0;
      tick(1);
   endtask
   task automatic fwd(input tlp_t t, input logic [PORT_W-1:0] p);
      wait_hi(o_ds_tx_valid);
      check(o_ds_tx_type, t);
      check(o_ds_tx_port, p);
      tick(1);
   endtask
   task automatic rsp(input tlp_t t, input logic [PORT_W-1:0] p);
      wait_hi(o_rsp_valid);
      check(o_rsp_type, t);
      check(o_rsp_port, p);
      tick(1);
   endtask
   task automatic cpl(input tlp_t t, input logic [PORT_W-1:0] p);
      i_ds_cpl_valid = 1'b1;
      i_ds_cpl_type = t;
      i_ds_cpl_port = p;
      wait_hi(o_ds_cpl_ready);
      tick(1);
      i_ds_cpl_valid = 1'b0;
      rsp(t, p);
   endtask
   task automatic msg(input logic [PORT_W-1:0] p);
      i_msg_valid = 1'b1;
      i_msg_type = TLP_MSG;
      i_msg_port = p;
      wait_hi(o_msg_ready);
      tick(1);
      i_msg_valid = 1'b0;
      rsp(TLP_MSG, p);
   endtask
   task automatic state(input logic [3:0] ds, input logic up, input logic [7:0] sts);
      check(o_blk_to_ds, ds);
      check(o_blk_to_up, up);
      check(o_switch_status_reg, sts);
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      logic r;
      {i_req_valid, i_ds_cpl_valid, i_ds_cpl_posted_pend, i_msg_valid, i_up_posted_pend} = '0;
      {i_req_port, i_ds_cpl_port, i_msg_port, i_ds_posted_pend} = '0;
      i_req_type = TLP_MWR;
      i_ds_cpl_type = TLP_CPL;
      i_msg_type = TLP_MSG;
      i_ds_tx_ready = 1'b1;
      i_rst = 1'b1;
      tick(16);
      i_rst = 1'b0;
      tick(2);
      state(4'h0, 1'b0, 8'h00);
      $display("test reset done");
      i_ds_posted_pend = 4'h2;
      send(TLP_MRDLK, 2'h1, r);
      tick(4);
      check(o_ds_tx_valid, 1'b0);
      i_ds_posted_pend = 4'h0;
      fwd(TLP_MRDLK, 2'h1);
      state(4'h2, 1'b0, 8'h00);
      check(o_lock_port, 2'h1);
      msg(2'h2);
      $display("test port lock done");
      i_ds_cpl_posted_pend = 1'b1;
      i_ds_cpl_valid = 1'b1;
      i_ds_cpl_type = TLP_CPLDLK;
      i_ds_cpl_port = 2'h1;
      tick(4);
      check(o_switch_status_reg, 8'h00);
      i_ds_cpl_posted_pend = 1'b0;
      cpl(TLP_CPLDLK, 2'h1);
      state(4'h2, 1'b1, 8'h01);
      check(o_sw_locked, 1'b1);
      msg(2'h1);
      send(TLP_MRDLK, 2'h1, r);
      fwd(TLP_MRDLK, 2'h1);
      cpl(TLP_CPLLK, 2'h1);
      send(TLP_MWR, 2'h1, r);
      fwd(TLP_MWR, 2'h1);
      state(4'h2, 1'b1, 8'h01);
      check(o_lock_port, 2'h1);
      check(o_lock_open, 1'b1);
      send(TLP_MRD, 2'h1, r);
      check(r, 1'b1);
      send(TLP_CFG, 2'h1, r);
      check(r, 1'b1);
      send(TLP_MRDLK, 2'h2, r);
      check(r, 1'b1);
      check(o_ds_tx_valid, 1'b0);
      $display("test switch lock done");
      i_msg_valid = 1'b1;
      i_msg_type = TLP_MSG;
      i_msg_port = 2'h2;
      i_up_posted_pend = 1'b1;
      send(TLP_UNLOCK, 2'h1, r);
      tick(4);
      check(o_switch_status_reg, 8'h01);
      check(o_msg_ready, 1'b0);
      i_up_posted_pend = 1'b0;
      fwd(TLP_UNLOCK, 2'h1);
      state(4'h0, 1'b0, 8'h00);
      msg(2'h2);
      $display("test unlock done");
      send(TLP_MRDLK, 2'h3, r);
      fwd(TLP_MRDLK, 2'h3);
      cpl(TLP_CPLLK, 2'h3);
      state(4'h8, 1'b1, 8'h00);
      send(TLP_UNLOCK, 2'h3, r);
      fwd(TLP_UNLOCK, 2'h3);
      state(4'h0, 1'b0, 8'h00);
      $display("test failed lock done");
      send(TLP_MRDLK, 2'h0, r);
      fwd(TLP_MRDLK, 2'h0);
      i_rst = 1'b1;
      tick(2);
      i_rst = 1'b0;
      tick(2);
      state(4'h0, 1'b0, 8'h00);
      check(o_lock_open, 1'b0);
      $display("test mid reset done");
      end_sim();
   end
endmodule
`default_nettype wire
